// >>> stdr_pkg.sv
/*
  constants for the sensor trim and debug register bank: byte offsets on
  the special-function register bus, field positions, reset values.
  assumes an 8-bit address and 8-bit data special-function register bus.
*/
package stdr_pkg;
  // ---------------------------------------------------------------
  // bus and field widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TRIM_W = 7;   // width of each trim field
  localparam int unsigned CODE_W = 6;   // width of restart test code
  localparam int unsigned BPH_W  = 6;   // breakpoint high bits
  localparam int unsigned BPL_W  = 8;   // breakpoint low byte
  localparam int unsigned BP_W   = 14;  // full breakpoint address

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] DEBUG_CTRL_OFS  = 8'h84;
  localparam logic [7:0] TEST_CODE_OFS   = 8'h91;
  localparam logic [7:0] BP_HIGH_OFS     = 8'h92;
  localparam logic [7:0] BP_LOW_OFS      = 8'h93;
  localparam logic [7:0] TRIM_BIT11_OFS  = 8'hbe;
  localparam logic [7:0] TRIM_BIT12_OFS  = 8'hbf;
  localparam logic [7:0] AFE_STATUS_OFS  = 8'hc0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned APPLY_BIT      = 7;  // trim apply-enable
  localparam int unsigned UART_EN_BIT    = 7;  // debug serial enable
  localparam int unsigned IRQ_EN_BIT     = 5;  // reset/test pin irq gate
  localparam int unsigned BP_IRQ_EN_BIT  = 4;  // breakpoint irq gate
  localparam int unsigned BG_OK_BIT      = 7;  // bandgap ready
  localparam int unsigned ADC_BUSY_BIT   = 6;  // conversion running
  localparam int unsigned ADC_RES_BIT    = 5;  // conversion result bit

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] TRIM_RST   = 7'h00;
  localparam logic [5:0] CODE_RST   = 6'h00;
  localparam logic [5:0] BPH_RST    = 6'h00;
  localparam logic [7:0] BPL_RST    = 8'h00;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [7:0] RDATA_RST  = 8'h00;
endpackage : stdr_pkg

// >>> stdr_bp_if.sv
/*
  carrier between the register bank and the breakpoint comparator.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface stdr_bp_if;
  import stdr_pkg::*;
  logic [BP_W-1:0] bp_addr;     // breakpoint address from registers
  logic            bp_enable;   // breakpoint interrupt enable
  logic            fetch_valid; // core fetches an instruction
  logic [BP_W-1:0] fetch_addr;  // program counter of that fetch
  logic            hit;         // one-cycle match pulse

  modport bank    (output bp_addr, bp_enable, fetch_valid, fetch_addr,
                   input hit);
  modport matcher (input bp_addr, bp_enable, fetch_valid, fetch_addr,
                   output hit);
endinterface : stdr_bp_if

// >>> stdr_bp_match.sv
/*
  breakpoint comparator: pulses hit for one cycle on a fetch whose
  address equals the programmed breakpoint while enabled.
  assumes fetch_valid is high for exactly one cycle per fetch.
*/
`timescale 1ns/1ps
module stdr_bp_match (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic timer_rst,
  stdr_bp_if.matcher bp
);
  import stdr_pkg::*;

  // ---------------------------------------------------------------
  // compare on fetch
  // ---------------------------------------------------------------
  // one pulse per matching fetch, so a loop sitting on the address
  // raises a request on each fetch and never a held level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bp.hit <= 1'b0;
    end else if (timer_rst) begin
      bp.hit <= 1'b0;
    end else begin
      bp.hit <= bp.bp_enable && bp.fetch_valid &&
                (bp.fetch_addr == bp.bp_addr);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_bp_hit_fires: assert property (
    (bp.bp_enable && bp.fetch_valid && bp.fetch_addr == bp.bp_addr && !timer_rst)
      |=> bp.hit)
    else $error("breakpoint match did not raise hit");
  a_bp_hit_cause: assert property (
    bp.hit |-> $past(bp.bp_enable) && $past(bp.fetch_valid))
    else $error("hit without enabled fetch");
endmodule : stdr_bp_match

// >>> stdr_regs.sv
/*
  sensor trim and debug register bank: byte-wide extended registers for
  offset trim of sensor bits 11 and 12, analog front status, debug
  controls, restart test code and program breakpoint.
  assumes the core drives a single-cycle byte write or read strobe with
  address and data synchronous to ref_clk; timer_rst is a synchronous
  one-cycle-or-longer pulse from the watchdog timer.
*/
// Notes on behaviour
// - 0xBE low seven bits hold bit-11 trim
// - 0xBF low seven bits hold bit-12 trim
// - 0xBF bit 7 applies all trim bytes
// - 0xC0 bit 7 shows bandgap ready
// - 0xC0 bit 6 shows conversion busy
// - 0xC0 bit 5 shows result, others zero
// - 0x84 bit 5 gates reset/test pin irq
// - 0x91 six-bit restart test code
// - 0x92/0x93 hold breakpoint bits, reset zero
// - breakpoint is high times 256 plus low
`timescale 1ns/1ps
module stdr_regs (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        timer_rst,
  // special-function register bus
  input  wire logic [stdr_pkg::ADDR_W-1:0] sfr_addr,
  input  wire logic                        sfr_wr,
  input  wire logic                        sfr_rd,
  input  wire logic [stdr_pkg::DATA_W-1:0] sfr_wdata,
  output logic      [stdr_pkg::DATA_W-1:0] sfr_rdata,
  // analog front end state
  input  wire logic                        bandgap_ready_in,
  input  wire logic                        adc_busy_in,
  input  wire logic                        adc_result_in,
  // interrupt source and core fetch
  input  wire logic                        reset_test_irq_in,
  input  wire logic                        fetch_valid,
  input  wire logic [stdr_pkg::BP_W-1:0]   fetch_addr,
  // control outputs
  output logic      [stdr_pkg::TRIM_W-1:0] offset_trim_bit11_field,
  output logic      [stdr_pkg::TRIM_W-1:0] offset_trim_bit12_field,
  output logic                             trim_apply_enable,
  output logic                             debug_uart_enable,
  output logic                             ext_irq_enable,
  output logic                             breakpoint_interrupt_enable,
  output logic      [stdr_pkg::CODE_W-1:0] restart_test_code,
  output logic      [stdr_pkg::BP_W-1:0]   breakpoint_match_address,
  output logic                             external_irq_zero
);
  import stdr_pkg::*;

  // ---------------------------------------------------------------
  // local state
  // ---------------------------------------------------------------
  logic [BPH_W-1:0] breakpoint_high_bits; // address bits 13..8
  logic [BPL_W-1:0] breakpoint_low_byte;  // address bits 7..0
  logic [2:0]       analog_front_status;  // ready, busy, result
  logic             wr_en;                // write not masked by reset
  stdr_bp_if        bp_link ();           // to breakpoint comparator

  // timer reset wins over a write in the same cycle
  assign wr_en = sfr_wr && !timer_rst;

  // ---------------------------------------------------------------
  // trim registers
  // ---------------------------------------------------------------
  // bit 7 of 0xBE is not implemented, write of it is dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_trim_bit11_field <= TRIM_RST;
    end else if (timer_rst) begin
      offset_trim_bit11_field <= TRIM_RST;
    end else if (wr_en && sfr_addr == TRIM_BIT11_OFS) begin
      offset_trim_bit11_field <= sfr_wdata[TRIM_W-1:0];
    end
  end

  // apply-enable and bit-12 trim share one byte; software is expected
  // to clear the trim field when it disables, we store what it writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_trim_bit12_field <= TRIM_RST;
      trim_apply_enable       <= 1'b0;
    end else if (timer_rst) begin
      offset_trim_bit12_field <= TRIM_RST;
      trim_apply_enable       <= 1'b0;
    end else if (wr_en && sfr_addr == TRIM_BIT12_OFS) begin
      offset_trim_bit12_field <= sfr_wdata[TRIM_W-1:0];
      trim_apply_enable       <= sfr_wdata[APPLY_BIT];
    end
  end

  // ---------------------------------------------------------------
  // debug control and test code
  // ---------------------------------------------------------------
  // reserved bits of 0x84 are accepted but kept nowhere
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_uart_enable           <= 1'b0;
      ext_irq_enable              <= 1'b0;
      breakpoint_interrupt_enable <= 1'b0;
    end else if (timer_rst) begin
      debug_uart_enable           <= 1'b0;
      ext_irq_enable              <= 1'b0;
      breakpoint_interrupt_enable <= 1'b0;
    end else if (wr_en && sfr_addr == DEBUG_CTRL_OFS) begin
      debug_uart_enable           <= sfr_wdata[UART_EN_BIT];
      ext_irq_enable              <= sfr_wdata[IRQ_EN_BIT];
      breakpoint_interrupt_enable <= sfr_wdata[BP_IRQ_EN_BIT];
    end
  end

  // code survives until the next restart so the core can read it back
  // through its own boot path, not through this bank
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_test_code <= CODE_RST;
    end else if (timer_rst) begin
      restart_test_code <= CODE_RST;
    end else if (wr_en && sfr_addr == TEST_CODE_OFS) begin
      restart_test_code <= sfr_wdata[CODE_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // breakpoint address
  // ---------------------------------------------------------------
  // high and low halves are written separately; a fetch between the
  // two writes compares against a half-updated address
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      breakpoint_high_bits <= BPH_RST;
      breakpoint_low_byte  <= BPL_RST;
    end else if (timer_rst) begin
      breakpoint_high_bits <= BPH_RST;
      breakpoint_low_byte  <= BPL_RST;
    end else if (wr_en && sfr_addr == BP_HIGH_OFS) begin
      breakpoint_high_bits <= sfr_wdata[BPH_W-1:0];
    end else if (wr_en && sfr_addr == BP_LOW_OFS) begin
      breakpoint_low_byte <= sfr_wdata;
    end
  end

  // high bits land at 13..8, i.e. high * 256 + low
  assign breakpoint_match_address = {breakpoint_high_bits, breakpoint_low_byte};

  // ---------------------------------------------------------------
  // analog front status and read path
  // ---------------------------------------------------------------
  // sampled every cycle; cleared by both resets so ready and busy read
  // zero until the analog side reports again
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_front_status <= STATUS_RST;
    end else if (timer_rst) begin
      analog_front_status <= STATUS_RST;
    end else begin
      analog_front_status <= {bandgap_ready_in, adc_busy_in, adc_result_in};
    end
  end

  // only the status byte reads back; write-only and unmapped read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= RDATA_RST;
    end else if (sfr_rd && sfr_addr == AFE_STATUS_OFS) begin
      sfr_rdata <= {analog_front_status, 5'h00};
    end else begin
      sfr_rdata <= RDATA_RST;
    end
  end

  // ---------------------------------------------------------------
  // interrupt request zero
  // ---------------------------------------------------------------
  assign bp_link.bp_addr     = breakpoint_match_address;
  assign bp_link.bp_enable   = breakpoint_interrupt_enable;
  assign bp_link.fetch_valid = fetch_valid;
  assign bp_link.fetch_addr  = fetch_addr;

  stdr_bp_match u_bp_match (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .timer_rst (timer_rst),
    .bp        (bp_link.matcher)
  );

  // both sources merge onto one request line, each behind its own gate
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      external_irq_zero <= 1'b0;
    end else if (timer_rst) begin
      external_irq_zero <= 1'b0;
    end else begin
      external_irq_zero <= (reset_test_irq_in && ext_irq_enable)
                           || bp_link.hit;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_trim11_write: assert property (
    wr_en && sfr_addr == TRIM_BIT11_OFS
      |=> offset_trim_bit11_field == $past(sfr_wdata[6:0]))
    else $error("bit-11 trim not stored");
  a_trim12_apply: assert property (
    wr_en && sfr_addr == TRIM_BIT12_OFS
      |=> trim_apply_enable == $past(sfr_wdata[7])
          && offset_trim_bit12_field == $past(sfr_wdata[6:0]))
    else $error("apply bit or bit-12 trim not stored");
  a_status_read: assert property (
    sfr_rd && sfr_addr == AFE_STATUS_OFS
      |=> sfr_rdata[7:5] == $past(analog_front_status) && sfr_rdata[4:0] == 5'h00)
    else $error("status read mismatch");
  a_status_reset: assert property (
    timer_rst ##1 (sfr_rd && sfr_addr == AFE_STATUS_OFS)
      |=> sfr_rdata[7:6] == 2'b00)
    else $error("ready or busy not cleared by timer reset");
  a_wo_reads_zero: assert property (
    sfr_rd && sfr_addr != AFE_STATUS_OFS |=> sfr_rdata == 8'h00)
    else $error("write-only or unmapped read not zero");
  a_irq_gated: assert property (
    !ext_irq_enable && !bp_link.hit |=> !external_irq_zero)
    else $error("irq zero raised while gated");
  a_irq_pin_pass: assert property (
    reset_test_irq_in && ext_irq_enable && !timer_rst |=> external_irq_zero)
    else $error("enabled pin request lost");
  a_test_code_write: assert property (
    wr_en && sfr_addr == TEST_CODE_OFS |=> restart_test_code == $past(sfr_wdata[5:0]))
    else $error("test code not stored");
  a_bp_high_place: assert property (
    wr_en && sfr_addr == BP_HIGH_OFS
      |=> breakpoint_match_address[13:8] == $past(sfr_wdata[5:0])
          && $stable(breakpoint_match_address[7:0]))
    else $error("breakpoint high bits misplaced");
  a_bp_timer_clear: assert property (
    timer_rst |=> breakpoint_match_address == 14'h0000 && restart_test_code == 6'h00)
    else $error("timer reset did not clear breakpoint");
  a_bp_irq_path: assert property (
    bp_link.hit && !timer_rst |=> external_irq_zero)
    else $error("breakpoint hit did not raise irq zero");

  c_apply_on: cover property (wr_en && sfr_addr == TRIM_BIT12_OFS && sfr_wdata[7]);
  c_bp_irq: cover property (breakpoint_interrupt_enable ##1 bp_link.hit ##1 external_irq_zero);
  c_busy_read: cover property (sfr_rd && sfr_addr == AFE_STATUS_OFS && analog_front_status[1]);
endmodule : stdr_regs

// >>> stdr_core_model.sv
/*
  behavioural model of the processor core on the far side of the bank:
  byte writes and reads on the special-function register bus and
  one-cycle instruction fetch pulses.
  assumes ref_clk is shared with the bank and calls come from one process.
*/
`timescale 1ns/1ps
module stdr_core_model (
  input  wire logic                        ref_clk,
  output logic      [stdr_pkg::ADDR_W-1:0] sfr_addr,
  output logic                             sfr_wr,
  output logic                             sfr_rd,
  output logic      [stdr_pkg::DATA_W-1:0] sfr_wdata,
  input  wire logic [stdr_pkg::DATA_W-1:0] sfr_rdata,
  output logic                             fetch_valid,
  output logic      [stdr_pkg::BP_W-1:0]   fetch_addr
);
  import stdr_pkg::*;
  // ---------------------------------------------------------------
  // idle bus
  // ---------------------------------------------------------------
  // released lines show the inverse so stale values never look valid
  initial begin
    sfr_addr    = 8'h00;
    sfr_wr      = 1'b0;
    sfr_rd      = 1'b0;
    sfr_wdata   = 8'h00;
    fetch_valid = 1'b0;
    fetch_addr  = 14'h0000;
  end
  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // one-cycle write strobe, returns just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_wr    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge ref_clk);
    sfr_wr    <= 1'b0;
    sfr_addr  <= ~a;
    sfr_wdata <= ~d;
    #1;
  endtask : wr
  // read data stands one cycle after the taking edge only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sfr_rd   <= 1'b1;
    sfr_addr <= a;
    @(posedge ref_clk);
    sfr_rd   <= 1'b0;
    sfr_addr <= ~a;
    #1;
    d = sfr_rdata;
  endtask : rd
  // switching trim off always zeroes the bit-12 field with it
  task automatic trim_off();
    wr(TRIM_BIT12_OFS, 8'h00);
  endtask : trim_off
  // one fetch pulse; returns in the time step of the taking edge
  task automatic fetch(input logic [13:0] a);
    @(posedge ref_clk);
    fetch_valid <= 1'b1;
    fetch_addr  <= a;
    @(posedge ref_clk);
    fetch_valid <= 1'b0;
    fetch_addr  <= ~a;
  endtask : fetch
endmodule : stdr_core_model

// >>> stdr_regs_test.sv
/*
  self-checking bench for the sensor trim and debug register bank.
  assumes the core model above and the package constants.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module stdr_regs_test;
  import stdr_pkg::*;
  logic        ref_clk, rst_n, timer_rst, bg, busy, res, pin_irq, fv;
  logic        wr, rd, irq, uart, ext_en, bp_en, apply;
  logic [7:0]  addr, wdata, rdata, v;
  logic [13:0] fa, bp;
  logic [6:0]  t11, t12;
  logic [5:0]  code;
  int          errors = 0;
  int          cmp_count = 0;
  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // bounded run: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end
  stdr_core_model u_stdr_core_model (.ref_clk(ref_clk), .sfr_addr(addr), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata), .fetch_valid(fv), .fetch_addr(fa));
  stdr_regs u_stdr_regs (.ref_clk(ref_clk), .rst_n(rst_n), .timer_rst(timer_rst),
    .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .bandgap_ready_in(bg), .adc_busy_in(busy), .adc_result_in(res),
    .reset_test_irq_in(pin_irq), .fetch_valid(fv), .fetch_addr(fa),
    .offset_trim_bit11_field(t11), .offset_trim_bit12_field(t12),
    .trim_apply_enable(apply), .debug_uart_enable(uart), .ext_irq_enable(ext_en),
    .breakpoint_interrupt_enable(bp_en), .restart_test_code(code),
    .breakpoint_match_address(bp), .external_irq_zero(irq));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // irq must pulse exactly one cycle after the taking edge, then stay low
  task automatic irq_seen(input logic e);
    @(posedge ref_clk);
    #1;
    `CHK(irq, e)
    repeat (3) begin
      @(posedge ref_clk);
      #1;
      `CHK(irq, 1'b0)
    end
  endtask : irq_seen
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_trim();
    u_stdr_core_model.wr(TRIM_BIT11_OFS, 8'hff);
    `CHK(t11, 7'h7f)
    u_stdr_core_model.wr(TRIM_BIT12_OFS, 8'h85);
    `CHK(t12, 7'h05)
    `CHK(apply, 1'b1)
    u_stdr_core_model.rd(TRIM_BIT11_OFS, v);
    `CHK(v, 8'h00)
    u_stdr_core_model.trim_off();
    `CHK({apply, t12}, 8'h00)
  endtask : t_trim
  // status is sampled a cycle before the read edge, so settle inputs first
  task automatic t_status(input logic [2:0] s);
    @(posedge ref_clk);
    {bg, busy, res} <= s;
    repeat (2) @(posedge ref_clk);
    u_stdr_core_model.rd(AFE_STATUS_OFS, v);
    `CHK(v, {s, 5'h00})
  endtask : t_status
  // pin request passes only while the gate bit is set
  task automatic t_pin(input logic [7:0] ctl, input logic e);
    u_stdr_core_model.wr(DEBUG_CTRL_OFS, ctl);
    `CHK({uart, ext_en, bp_en}, {ctl[7], ctl[5], ctl[4]})
    @(posedge ref_clk);
    pin_irq <= 1'b1;
    @(posedge ref_clk);
    pin_irq <= 1'b0;
    #1;
    `CHK(irq, e)
  endtask : t_pin
  task automatic t_break();
    u_stdr_core_model.wr(TEST_CODE_OFS, 8'hff);
    `CHK(code, 6'h3f)
    u_stdr_core_model.wr(BP_HIGH_OFS, 8'hff);
    u_stdr_core_model.wr(BP_LOW_OFS, 8'h5a);
    `CHK(bp, 14'h3f5a)
    u_stdr_core_model.wr(DEBUG_CTRL_OFS, 8'h10);
    u_stdr_core_model.fetch(14'h3f5a);
    irq_seen(1'b1);
    u_stdr_core_model.fetch(14'h3f5b);
    irq_seen(1'b0);
    u_stdr_core_model.wr(DEBUG_CTRL_OFS, 8'h00);
    u_stdr_core_model.fetch(14'h3f5a);
    irq_seen(1'b0);
  endtask : t_break
  // stray writes change nothing; timer reset clears everything written
  task automatic t_timer();
    u_stdr_core_model.wr(8'h00, 8'hff);
    u_stdr_core_model.wr(AFE_STATUS_OFS, 8'hff);
    `CHK({t11, code, bp}, {7'h7f, 6'h3f, 14'h3f5a})
    // load every control so the timer reset has something to clear
    u_stdr_core_model.wr(DEBUG_CTRL_OFS, 8'hb0);
    u_stdr_core_model.wr(TRIM_BIT12_OFS, 8'h85);
    `CHK({uart, ext_en, bp_en, apply, t12}, 11'h785)
    @(posedge ref_clk);
    {bg, busy, res} <= 3'h7;
    timer_rst       <= 1'b1;
    // read while the timer reset is held: ready and busy read zero
    u_stdr_core_model.rd(AFE_STATUS_OFS, v);
    `CHK(v[7:6], 2'b00)
    @(posedge ref_clk);
    timer_rst <= 1'b0;
    #1;
    `CHK({t11, t12, apply, uart, code, bp, ext_en, bp_en}, 38'h0)
    // after release the status follows the analog side again
    u_stdr_core_model.rd(AFE_STATUS_OFS, v);
    `CHK(v, 8'he0)
  endtask : t_timer
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, timer_rst, bg, busy, res, pin_irq} = 6'h00;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    `CHK({t11, t12, apply, uart, code, bp, irq, ext_en, bp_en}, 39'h0)
    t_status(3'h0);
    t_trim();
    t_status(3'h5);
    t_status(3'h2);
    t_pin(8'hff, 1'b1);
    t_pin(8'h90, 1'b0);
    t_break();
    t_timer();
    tally_and_finish();
  end
endmodule : stdr_regs_test
